// File: logic/acq_timing_regs.vh
// Purpose: Constants for the acquisition timing sequencer.
// Assumes: 10 MHz system clock, 100 ns period.
// Notes: Times are held in microseconds and converted to clock cycles here.
`ifndef ACQ_TIMING_REGS_VH
`define ACQ_TIMING_REGS_VH
`define CLK_PERIOD_NS 100
`define SHUT_NORMAL 2'h0
`define SHUT_CLOSED 2'h1
`define SHUT_OPEN 2'h2
`define CLEAN_CYCLE_US 10
`define CLEAN_CYCLE_CYC ((`CLEAN_CYCLE_US * 1000) / `CLK_PERIOD_NS)
`define CNT_W 32
`endif

// File: logic/phase_timer.v
// Purpose: Loadable down-counter that marks the end of a timed phase.
// Assumes: The caller may load while the count runs; the load then wins over the count.
// Notes: A load of zero is treated as one cycle so no phase is skipped.
`timescale 1ns/10ps
`default_nettype none
module phase_timer #(
   parameter W = 32
) (
   input wire clk_i,
   input wire reset_n_i,
   input wire load_i,
   input wire [W-1:0] value_i,
   output wire done_o
);
   reg [W-1:0] count_reg;
   reg [W-1:0] count_next;

   always @* begin
      count_next = count_reg;
      if (load_i) begin
         count_next = (value_i == {W{1'b0}}) ? {{(W-1){1'b0}}, 1'b1} : value_i;
      end else if (count_reg != {W{1'b0}}) begin
         count_next = count_reg - {{(W-1){1'b0}}, 1'b1};
      end
   end

   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         count_reg <= {W{1'b0}};
      end else begin
         count_reg <= count_next;
      end
   end

   // Done ignores the load so a caller may reload on done without a combinational loop.
   assign done_o = (count_reg == {{(W-1){1'b0}}, 1'b1});
endmodule
`default_nettype wire

// File: logic/acquisition_timing_sequencer.v
// Purpose: Sequences shutter, cleaning, exposure and readout for frame acquisition.
// Assumes: Commands and trigger are synchronous one-clock or level inputs.
// Notes: Exposure, compensation and readout lengths are given in clock cycles.
// Notes: A stop during readout takes effect only if it is still present in the last readout cycle, after the frame has ended.
`timescale 1ns/10ps
`default_nettype none
`include "acq_timing_regs.vh"
module acquisition_timing_sequencer #(
   parameter W = `CNT_W,
   // Length of one clean cycle; a trigger waits for the running cycle to finish.
   parameter [W-1:0] CLEAN_CYCLES = `CLEAN_CYCLE_CYC
) (
   input wire clk_i,
   input wire reset_n_i,
   input wire begin_acquisition_cmd_i,
   input wire stop_acquisition_cmd_i,
   input wire free_streaming_i,
   input wire ext_trigger_mode_i,
   input wire [1:0] shutter_ctrl_i,
   input wire continuous_clean_i,
   input wire pre_open_i,
   input wire ext_trigger_i,
   input wire [W-1:0] exposure_cycles_i,
   input wire [W-1:0] compensation_cycles_i,
   input wire [W-1:0] readout_cycles_i,
   output reg shutter_open_o,
   output reg cleaning_o,
   output reg readout_active_n_o,
   output reg acquiring_o,
   output reg frame_done_o
);
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_WAIT_TRIG = 3'h1;
   localparam [2:0] ST_EXPOSE = 3'h2;
   localparam [2:0] ST_COMP = 3'h3;
   localparam [2:0] ST_READ = 3'h4;

   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg clean_run_reg;
   reg trig_held_reg;
   reg clean_ld;
   reg phase_ld;
   reg [W-1:0] phase_val;
   wire phase_done;
   wire clean_done;
   wire clean_en;
   wire preopen_en;
   wire trig_seen;
   reg shut_next;
   reg cleaning_next;
   reg readout_n_next;
   reg acquiring_next;
   reg frame_done_next;

   // Options are qualified here so illegal combinations simply have no effect.
   assign clean_en = ext_trigger_mode_i & continuous_clean_i;
   assign preopen_en = ext_trigger_mode_i & pre_open_i
                       & (shutter_ctrl_i == `SHUT_NORMAL);
   // A trigger in free-run is never looked at.
   assign trig_seen = ext_trigger_mode_i & (ext_trigger_i | trig_held_reg);

   // Decides the shutter level for a state, honouring disabled choices.
   function shutter_for;
      input [1:0] ctrl;
      input expose;
      input pre;
      begin
         case (ctrl)
            `SHUT_CLOSED: shutter_for = 1'b0;
            `SHUT_OPEN: shutter_for = 1'b1;
            default: shutter_for = expose | pre;
         endcase
      end
   endfunction

   // One timer serves exposure, compensation and readout in turn, since those phases never
   // overlap; cleaning has its own so that it can run while the frame timer is idle.
   phase_timer #(.W(W)) u_phase (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .load_i(phase_ld),
      .value_i(phase_val),
      .done_o(phase_done)
   );

   phase_timer #(.W(W)) u_clean (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .load_i(clean_ld),
      .value_i(CLEAN_CYCLES),
      .done_o(clean_done)
   );

   always @* begin
      state_next = state_reg;
      phase_ld = 1'b0;
      phase_val = exposure_cycles_i;
      clean_ld = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            // Frame-by-frame waits here for the host's next start.
            if (begin_acquisition_cmd_i) begin
               if (ext_trigger_mode_i) begin
                  state_next = ST_WAIT_TRIG;
                  clean_ld = clean_en;
               end else begin
                  state_next = ST_EXPOSE;
                  phase_ld = 1'b1;
               end
            end
         end
         ST_WAIT_TRIG: begin
            // A clean cycle in progress finishes before the frame starts.
            if (clean_run_reg && !clean_done) begin
               state_next = ST_WAIT_TRIG;
            end else if (trig_seen) begin
               state_next = ST_EXPOSE;
               phase_ld = 1'b1;
            end else if (clean_en) begin
               clean_ld = 1'b1;
            end
         end
         ST_EXPOSE: begin
            // The shutter closes here and the compensation wait begins.
            if (phase_done) begin
               state_next = ST_COMP;
               phase_ld = 1'b1;
               phase_val = compensation_cycles_i;
            end
         end
         ST_COMP: begin
            if (phase_done) begin
               state_next = ST_READ;
               phase_ld = 1'b1;
               phase_val = readout_cycles_i;
            end
         end
         ST_READ: begin
            // A stop is honoured here only in the last readout cycle, so the frame is never cut short.
            if (phase_done) begin
               if (!free_streaming_i || stop_acquisition_cmd_i) begin
                  state_next = ST_IDLE;
               end else if (ext_trigger_mode_i) begin
                  state_next = ST_WAIT_TRIG;
                  clean_ld = clean_en;
               end else begin
                  state_next = ST_EXPOSE;
                  phase_ld = 1'b1;
               end
            end
         end
         default: state_next = ST_IDLE;
      endcase
      // Outside readout a stop wins over every other move and cancels pending loads.
      if (stop_acquisition_cmd_i && state_reg != ST_READ) begin
         state_next = ST_IDLE;
         phase_ld = 1'b0;
         clean_ld = 1'b0;
      end
   end

   // The shutter follows the next state, so it moves on the same edge as the phase.
   always @* begin
      shut_next = shutter_for(shutter_ctrl_i, state_next == ST_EXPOSE,
                              preopen_en && state_next == ST_WAIT_TRIG);
   end

   // Outputs other than frame done are decoded from the next state so that they line up with the state flops; frame done comes from the current state and phase done.
   always @* begin
      cleaning_next = clean_ld | (clean_run_reg & ~clean_done);
      if (state_next == ST_IDLE) begin
         // A stop while waiting drops the clean in flight, so nothing runs while idle.
         cleaning_next = 1'b0;
      end
      readout_n_next = ~(state_next == ST_READ);
      acquiring_next = (state_next != ST_IDLE);
      frame_done_next = (state_reg == ST_READ) && phase_done;
   end

   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_reg <= ST_IDLE;
         clean_run_reg <= 1'b0;
         trig_held_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         // A fresh load wins over the end of the previous clean cycle.
         if (clean_ld) begin
            clean_run_reg <= 1'b1;
         end else if (clean_done || state_next == ST_IDLE) begin
            clean_run_reg <= 1'b0;
         end
         // A trigger landing mid-clean is saved until the clean cycle ends.
         if (state_next != ST_WAIT_TRIG) begin
            trig_held_reg <= 1'b0;
         end else if (ext_trigger_i && ext_trigger_mode_i) begin
            trig_held_reg <= 1'b1;
         end
      end
   end

   // Output flops sit apart from the state flops; their reset levels are the idle levels, with the shutter closed even under SHUT_OPEN.
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         shutter_open_o <= 1'b0;
         cleaning_o <= 1'b0;
         readout_active_n_o <= 1'b1;
         acquiring_o <= 1'b0;
         frame_done_o <= 1'b0;
      end else begin
         shutter_open_o <= shut_next;
         cleaning_o <= cleaning_next;
         readout_active_n_o <= readout_n_next;
         acquiring_o <= acquiring_next;
         frame_done_o <= frame_done_next;
      end
   end
endmodule
`default_nettype wire

// File: test/host_model.sv
// Purpose: Host side that paces frames with start and stop commands.
// Assumes: Frame done is a one-cycle pulse.
// Notes: The gap input makes the host answer promptly or slowly.
`timescale 1ns/10ps
`default_nettype none
module host_model (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic run_i,
   input wire logic stream_i,
   input wire logic frame_done_i,
   input wire logic [3:0] gap_i,
   output logic begin_o,
   output logic stop_o
);
   logic armed;
   logic [3:0] wait_q;
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         begin_o <= 1'b0;
         stop_o <= 1'b0;
         armed <= 1'b1;
         wait_q <= 4'h0;
      end else begin
         stop_o <= frame_done_i && !stream_i;
         begin_o <= 1'b0;
         if (frame_done_i && !stream_i) begin
            armed <= 1'b1;
            wait_q <= gap_i;
         end else if (armed && run_i && wait_q != 4'h0) begin
            wait_q <= wait_q - 4'h1;
         end else if (armed && run_i) begin
            begin_o <= 1'b1;
            armed <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// File: test/acquisition_timing_sequencer_properties.sv
// Purpose: Port relations of the acquisition sequencer.
// Assumes: Mode inputs change only while reset is held.
// Notes: Phase lengths vary per case, so the bench measures them.
`timescale 1ns/10ps
`default_nettype none
`include "acq_timing_regs.vh"
module acq_seq_checker (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic free_streaming_i,
   input wire logic ext_trigger_mode_i,
   input wire logic [1:0] shutter_ctrl_i,
   input wire logic continuous_clean_i,
   input wire logic pre_open_i,
   input wire logic shutter_open_o,
   input wire logic cleaning_o,
   input wire logic readout_active_n_o,
   input wire logic acquiring_o,
   input wire logic frame_done_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   a_idle_no_readout: assert property (!acquiring_o |-> readout_active_n_o)
      else $error("readout while idle");
   a_done_ends_readout: assert property ($rose(readout_active_n_o) |-> frame_done_o)
      else $error("readout end without done");
   a_fbf_idles: assert property (frame_done_o && !free_streaming_i |-> !acquiring_o)
      else $error("no idle after frame");
   a_stream_runs: assert property (frame_done_o && free_streaming_i |-> acquiring_o)
      else $error("streaming stopped");
   a_clean_gate: assert property (cleaning_o |-> ext_trigger_mode_i && acquiring_o)
      else $error("cleaning outside wait");
   a_hold_closed: assert property (shutter_ctrl_i == `SHUT_CLOSED |=> !shutter_open_o)
      else $error("held shutter opened");
   a_hold_open: assert property (shutter_ctrl_i == `SHUT_OPEN |=> shutter_open_o)
      else $error("held shutter closed");
   a_no_overlap: assert property (!readout_active_n_o && shutter_ctrl_i != `SHUT_OPEN
      |-> !shutter_open_o) else $error("exposure overlaps readout");
   a_comp_gap: assert property ($fell(shutter_open_o) |-> readout_active_n_o)
      else $error("no compensation gap");
   a_pre_open: assert property ($rose(acquiring_o) && ext_trigger_mode_i && pre_open_i
      && shutter_ctrl_i == `SHUT_NORMAL |-> shutter_open_o) else $error("no pre-open");
   a_ext_waits: assert property ($rose(acquiring_o) && ext_trigger_mode_i && !pre_open_i
      && shutter_ctrl_i != `SHUT_OPEN |-> !shutter_open_o) else $error("open early");
   a_free_open: assert property ($rose(acquiring_o) && !ext_trigger_mode_i
      && shutter_ctrl_i == `SHUT_NORMAL |-> shutter_open_o) else $error("late open");
   a_clean_starts: assert property ($rose(acquiring_o) && ext_trigger_mode_i
      && continuous_clean_i |-> cleaning_o) else $error("no cleaning while waiting");
   a_clean_option: assert property (cleaning_o |-> continuous_clean_i)
      else $error("cleaning not selected");
endmodule
bind acquisition_timing_sequencer acq_seq_checker acq_seq_checker_i (.*);
`default_nettype wire

// File: test/acquisition_timing_sequencer_bench.sv
// Purpose: Frame timing bench over the timing and shutter modes.
// Assumes: Trigger pulses arrive at random in every mode.
// Notes: A reset starts each case, which also stops streaming left from the case before.
`timescale 1ns/10ps
`default_nettype none
module acquisition_timing_sequencer_bench;
   logic clk_i = 0, reset_n_i = 0, stream = 0, ext = 0, clean = 0, pre = 0, trig = 0, run = 0;
   logic [1:0] shut = 0;
   logic [3:0] gap = 0;
   logic [31:0] expo = 1, comp = 1, rdo = 1, rs = 81, ts = 81, sh_cnt = 0, ro_cnt = 0, ex_r;
   logic bg, sp, sh, cl, ro_n, acq, done;
   logic [31:0] q_ro[$], q_sh[$];
   logic [5:0] cfg[6] = '{6'h03, 6'h24, 6'h12, 6'h17, 6'h11, 6'h3a};
   int bad_count = 0, n_compared = 0, cyc = 0;
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %0d seen %0d", what, exp, seen);
      end
   endtask
   task stop_test;
      $display("compared %0d mismatched %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      forever #50 clk_i = ~clk_i;
   end
   host_model host_model_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .run_i(run), .stream_i(stream),
      .frame_done_i(done), .gap_i(gap), .begin_o(bg), .stop_o(sp));
   acquisition_timing_sequencer #(.CLEAN_CYCLES(32'h3)) acquisition_timing_sequencer_i (
      .clk_i(clk_i), .reset_n_i(reset_n_i), .begin_acquisition_cmd_i(bg),
      .stop_acquisition_cmd_i(sp), .free_streaming_i(stream), .ext_trigger_mode_i(ext),
      .shutter_ctrl_i(shut), .continuous_clean_i(clean), .pre_open_i(pre), .ext_trigger_i(trig),
      .exposure_cycles_i(expo), .compensation_cycles_i(comp), .readout_cycles_i(rdo),
      .shutter_open_o(sh), .cleaning_o(cl), .readout_active_n_o(ro_n), .acquiring_o(acq),
      .frame_done_o(done));
   // Random trigger pulses in free run must leave frame timing untouched.
   always @(posedge clk_i) begin
      ts <= xs(ts);
      trig <= ts[2:0] == 3'h0;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         stop_test();
      end
   end
   always @(negedge clk_i) begin
      if (!reset_n_i) begin
         sh_cnt <= 0;
         ro_cnt <= 0;
      end else if (done) begin
         check("readout length", ro_cnt, q_ro[0]);
         if (q_sh[0] !== 32'hffffffff) check("shutter time", sh_cnt, q_sh[0]);
         check("acquiring after frame", 32'(acq), 32'(stream));
         check("cleaning after frame", 32'(cl), 32'(stream && ext && clean));
         void'(q_ro.pop_front());
         void'(q_sh.pop_front());
         sh_cnt <= 32'(sh);
         ro_cnt <= 0;
      end else begin
         sh_cnt <= sh_cnt + 32'(sh);
         ro_cnt <= ro_cnt + 32'(!ro_n);
      end
   end
   initial begin
      for (int k = 0; k < 6; k++) begin
         @(posedge clk_i);
         reset_n_i <= 0;
         run <= 0;
         {stream, ext, shut, clean, pre} <= cfg[k];
         rs = xs(rs);
         ex_r = 32'(rs[5:4]) + 32'h1;
         expo <= 32'(rs[1:0]) + 32'h1;
         comp <= 32'(rs[3:2]) + 32'h1;
         rdo <= ex_r;
         gap <= rs[9:6];
         repeat (k == 0 ? 16 : 2) @(posedge clk_i);
         for (int f = 0; f < 3; f++) begin
            q_ro.push_back(ex_r);
            if (shut == 2'h2 || (ext && pre && shut == 2'h0)) q_sh.push_back(32'hffffffff);
            else q_sh.push_back(shut == 2'h1 ? 32'h0 : expo);
         end
         reset_n_i <= 1;
         run <= 1;
         wait (q_ro.size() == 0);
         $display("test %0d done", k);
      end
      stop_test();
   end
endmodule
`default_nettype wire
